/* File: core/boot_regs.vh */
// Constants for the boot download handshake: command codes, status bytes, strap codes
`ifndef BOOT_REGS_VH
`define BOOT_REGS_VH
`define CMD_SOFT_RESTART 24'h000001
`define CMD_RESERVED_A 24'h000002
`define CMD_RESERVED_B 24'h000003
`define CMD_START_DOWNLOAD 24'h000004
`define CMD_ACCEPT_ACK 24'h000005
`define ST_READY_FOR_IMAGE 8'h01
`define ST_IMAGE_ACCEPTED 8'h02
`define ST_PART_MISMATCH 8'hF0
`define ST_LOAD_FAULT_A 8'hFA
`define ST_UNKNOWN_COMMAND 8'hFB
`define ST_LOAD_FAULT_B 8'hFC
`define ST_SETUP_FAULT_A 8'hFD
`define ST_SETUP_FAULT_B 8'hFE
`define ST_BAD_CHECKSUM 8'hFF
`define STRAP_SERIAL 2'h0
`define FIFO_DEPTH_RST 32
`define BYTE_CNT_RST 2'h0
`endif

/* File: core/host_boot_download_handshake.v */
// Boot download handshake: inbound byte FIFO and the boot sequencer top
// Operation
// - Mode straps are sampled when hard reset releases; they pick serial or parallel.
// - Start-download code 0x000004 prepares the device to accept an image.
// - Successful preparation returns ready-for-image byte 0x01.
// - Failed preparation returns 0xFD/0xFE, 0xFB or 0xFA/0xFC, then stalls until reset.
// - Image ends in three-byte checksum; a match returns 0x02.
// - Checksum mismatch returns 0xFF and stalls until hard reset.
// - Acknowledge 0x000005 triggers internal application reset and starts the code.
// - Serial mode: host reads only after the device pulls attention low.
// - Commands are three bytes: restart 0x000001, 0x000002/3 reserved; replies single bytes.
// - After download the device waits for the begin-decode message before decoding.
// - Image not matching the part returns 0xF0 after the application starts.
`timescale 1ns/10ps
`include "boot_regs.vh"

module byte_fifo
#(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW = 5
)
(
	input wire sys_clk, // System clock
	input wire sys_rst, // Synchronous reset, high
	input wire in_valid, // Write request
	input wire [WIDTH-1:0] in_data, // Write data
	output wire in_ready, // Space available
	output wire out_valid, // Data available
	output wire [WIDTH-1:0] out_data, // Head of queue
	input wire out_ready // Consumer takes head
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	reg space_reg;
	wire push;
	wire pop;
	wire [AW:0] count_next;
	// Full and empty come from the count; space is a flop so the output pin is clean
	assign in_ready = space_reg;
	assign out_valid = (count_reg != 0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Storage written by index, no reset needed on data
	always @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Pointers wrap at DEPTH so non-power-of-two depths work
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			space_reg <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			space_reg <= (count_next != DEPTH);
		end
	end
endmodule // byte_fifo

module host_boot_download_handshake
#(
	parameter FIFO_DEPTH = `FIFO_DEPTH_RST,
	parameter FIFO_AW = 5
)
(
	input wire sys_clk, // 20 MHz system clock
	input wire sys_rst, // Hard reset, synchronous, high
	input wire wr_strap_n, // Write strap pin
	input wire rd_strap_n, // Read strap pin
	input wire psel_strap, // Protocol select pin
	input wire host_wr_valid, // Host byte offered
	input wire [7:0] host_wr_data, // Host byte, MSB first
	input wire host_wr_last, // Final byte of the image
	output wire host_wr_ready, // Inbound space, back-pressure
	input wire host_rd_strobe, // Host has read the status byte
	output reg [7:0] status_byte_reg, // Outgoing status byte
	output reg out_ready_reg, // Status byte pending
	output reg host_attention_n_reg, // Interrupt request, low active
	input wire setup_fault, // Preparation could not complete
	input wire part_match, // Image suits this part
	input wire begin_decode_msg, // Begin-decode message seen
	output reg app_reset_reg, // One-cycle internal application reset
	output reg decoding_reg, // Audio decode running
	output reg stalled_reg, // Waiting for hard reset
	output reg serial_mode_reg // Strapped serial control mode
);
	localparam S_CMD = 6'h01;
	localparam S_IMAGE = 6'h02;
	localparam S_ACK = 6'h04;
	localparam S_APP = 6'h08;
	localparam S_RUN = 6'h10;
	localparam S_STALL = 6'h20;
	reg [5:0] state_reg;
	reg [2:0] strap_meta_reg;
	reg [2:0] strap_sync_reg;
	reg strap_taken_reg;
	reg [23:0] word_reg;
	reg [1:0] byte_cnt_reg;
	reg [23:0] sum_reg;
	wire fifo_valid;
	wire [8:0] fifo_data;
	wire take;
	wire [23:0] word_full;
	wire word_done;
	// Append one byte to the assembling word, high byte arrives first
	function [23:0] shift_in;
		input [23:0] w;
		input [7:0] b;
		begin
			shift_in = {w[15:0], b};
		end
	endfunction

	byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) in_fifo
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(host_wr_valid),
		.in_data({host_wr_last, host_wr_data}),
		.in_ready(host_wr_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(take)
	);
	// Drain only while no reply waits; a stalled device lets the FIFO fill
	assign take = fifo_valid && !out_ready_reg && !app_reset_reg
		&& ((state_reg == S_CMD) || (state_reg == S_IMAGE) || (state_reg == S_ACK));
	assign word_full = shift_in(word_reg, fifo_data[7:0]);
	assign word_done = (byte_cnt_reg == 2'h2);
	// Strap pins pass two flops before anything looks at them
	always @(posedge sys_clk)
	begin
		strap_meta_reg <= {wr_strap_n, rd_strap_n, psel_strap};
		strap_sync_reg <= strap_meta_reg;
	end

	// Straps caught once, on the first clocked cycle after reset release
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			strap_taken_reg <= 1'b0;
			serial_mode_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			strap_taken_reg <= 1'b1;
			serial_mode_reg <= (strap_sync_reg[2:1] == `STRAP_SERIAL);
		end
	end

	// Boot sequencer
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= S_CMD;
			word_reg <= 24'h000000;
			byte_cnt_reg <= `BYTE_CNT_RST;
			sum_reg <= 24'h000000;
			status_byte_reg <= 8'h00;
			out_ready_reg <= 1'b0;
			app_reset_reg <= 1'b0;
			decoding_reg <= 1'b0;
			stalled_reg <= 1'b0;
		end
		else
		begin
			app_reset_reg <= 1'b0;
			// Byte stays put until the host reads it
			if (host_rd_strobe)
				out_ready_reg <= 1'b0;
			if (take)
			begin
				word_reg <= word_full;
				byte_cnt_reg <= word_done ? 2'h0 : byte_cnt_reg + 1'b1;
			end
			case (state_reg)
				S_CMD:
				begin
					if (take && word_done)
					begin
						out_ready_reg <= 1'b1;
						if (word_full == `CMD_START_DOWNLOAD && !setup_fault)
						begin
							status_byte_reg <= `ST_READY_FOR_IMAGE;
							sum_reg <= 24'h000000;
							state_reg <= S_IMAGE;
						end
						else if (word_full == `CMD_START_DOWNLOAD)
						begin
							status_byte_reg <= `ST_SETUP_FAULT_A;
							state_reg <= S_STALL;
						end
						else if (word_full == `CMD_SOFT_RESTART)
						begin
							out_ready_reg <= 1'b0;
							app_reset_reg <= 1'b1;
						end
						else
						begin
							// Reserved codes count as unknown too
							status_byte_reg <= `ST_UNKNOWN_COMMAND;
							state_reg <= S_STALL;
						end
					end
				end
				S_IMAGE:
				begin
					if (take && word_done && fifo_data[8])
					begin
						out_ready_reg <= 1'b1;
						status_byte_reg <= (word_full == sum_reg) ? `ST_IMAGE_ACCEPTED
							: `ST_BAD_CHECKSUM;
						state_reg <= (word_full == sum_reg) ? S_ACK : S_STALL;
					end
					else if (take && fifo_data[8])
					begin
						// Image not a whole number of words
						out_ready_reg <= 1'b1;
						status_byte_reg <= `ST_LOAD_FAULT_A;
						state_reg <= S_STALL;
					end
					else if (take && word_done)
						sum_reg <= sum_reg + word_full;
				end
				S_ACK:
				begin
					if (take && word_done)
					begin
						if (word_full == `CMD_ACCEPT_ACK)
						begin
							app_reset_reg <= 1'b1;
							state_reg <= S_APP;
							if (!part_match)
							begin
								out_ready_reg <= 1'b1;
								status_byte_reg <= `ST_PART_MISMATCH;
							end
						end
						else
						begin
							out_ready_reg <= 1'b1;
							status_byte_reg <= `ST_UNKNOWN_COMMAND;
							state_reg <= S_STALL;
						end
					end
				end
				S_APP:
				begin
					// Wrong-part code never initialises, so never decodes
					if (begin_decode_msg && part_match)
					begin
						decoding_reg <= 1'b1;
						state_reg <= S_RUN;
					end
				end
				S_RUN:
					decoding_reg <= 1'b1;
				S_STALL:
					stalled_reg <= 1'b1;
				default:
					state_reg <= S_CMD;
			endcase
		end
	end

	// Attention falls a cycle after output-ready rises, releases on the edge that clears it, serial mode only
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			host_attention_n_reg <= 1'b1;
		else
			host_attention_n_reg <= !(out_ready_reg && serial_mode_reg && !host_rd_strobe);
	end
endmodule // host_boot_download_handshake

/* File: tb/boot_props.sv */
// Checker of the boot handshake's port behaviour
`timescale 1ns/10ps
module boot_props #(parameter FIFO_DEPTH = 32)
(
	input wire sys_clk, // Clock
	input wire sys_rst, // Reset
	input wire host_rd_strobe, // Read
	input wire [7:0] status_byte_reg, // Status
	input wire out_ready_reg, // Pending
	input wire host_attention_n_reg, // Attention
	input wire part_match, // Part fits
	input wire begin_decode_msg, // Go
	input wire app_reset_reg, // App reset
	input wire decoding_reg, // Running
	input wire stalled_reg, // Stalled
	input wire serial_mode_reg // Serial
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Attention trails a fresh status by one cycle, never in parallel mode
	property p_att;
		$rose(out_ready_reg) && serial_mode_reg |=> !host_attention_n_reg;
	endproperty
	a_att: assert property (p_att) else $error("attention late");
	property p_par;
		!serial_mode_reg |-> host_attention_n_reg;
	endproperty
	a_par: assert property (p_par) else $error("attention in parallel");
	// Byte must not vanish before the host reads it
	property p_hold;
		out_ready_reg && !host_rd_strobe |=> out_ready_reg && $stable(status_byte_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("status lost");
	property p_stall;
		stalled_reg |=> stalled_reg;
	endproperty
	a_stall: assert property (p_stall) else $error("stall left");
	property p_fault;
		$rose(stalled_reg) |-> ##[0:2] status_byte_reg inside {8'hFA, 8'hFB, 8'hFD, 8'hFF};
	endproperty
	a_fault: assert property (p_fault) else $error("stall code");
	property p_dec;
		$rose(decoding_reg) |-> $past(begin_decode_msg) && $past(part_match);
	endproperty
	a_dec: assert property (p_dec) else $error("early decode");
	property p_app;
		app_reset_reg |=> !app_reset_reg;
	endproperty
	a_app: assert property (p_app) else $error("long app reset");
	property p_nodec;
		stalled_reg |-> !decoding_reg;
	endproperty
	a_nodec: assert property (p_nodec) else $error("decode in stall");
	c_run: cover property ($rose(decoding_reg));
	c_stall: cover property ($rose(stalled_reg));
	c_app: cover property (app_reset_reg);
endmodule // boot_props
bind host_boot_download_handshake boot_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.sys_clk,
	.sys_rst, .host_rd_strobe, .status_byte_reg, .out_ready_reg, .host_attention_n_reg,
	.part_match, .begin_decode_msg, .app_reset_reg, .decoding_reg, .stalled_reg,
	.serial_mode_reg);

/* File: tb/host_model.sv */
// Host controller model on the boot control port
`timescale 1ns/10ps
module host_model
(
	input wire sys_clk, // Clock
	output logic host_wr_valid, // Byte offered
	output logic [7:0] host_wr_data, // Byte
	output logic host_wr_last, // Final byte
	input wire host_wr_ready, // Space
	output logic host_rd_strobe, // Read done
	input wire host_attention_n_reg, // Attention
	input wire [7:0] status_byte_reg // Status byte read by the host
);
	initial
	begin
		host_wr_valid = 0;
		host_wr_data = 8'h00;
		host_wr_last = 0;
		host_rd_strobe = 0;
	end
	// One byte held until the buffer takes it
	task put(input [7:0] d, input l);
		logic ok;
		begin
			host_wr_valid = 1;
			host_wr_data = d;
			host_wr_last = l;
			do
			begin
				ok = host_wr_ready;
				@(posedge sys_clk);
				#1;
			end while (!ok);
		end
	endtask
	// Release with inverted data so no stale byte lingers, then let an edge pass
	task idle;
		begin
			host_wr_valid = 0;
			host_wr_data = ~host_wr_data;
			host_wr_last = 0;
			@(posedge sys_clk);
			#1;
		end
	endtask
	// Three-byte word, high byte first
	task send(input [23:0] w, input l);
		integer i;
		begin
			for (i = 2; i >= 0; i--)
				put(w[8*i+:8], l && i == 0);
			idle;
		end
	endtask
	// Read once attention is low, or after 99 cycles at most
	task get(output [7:0] b);
		integer i;
		begin
			for (i = 0; i < 99 && host_attention_n_reg; i++)
			begin
				@(posedge sys_clk);
				#1;
			end
			b = status_byte_reg;
			host_rd_strobe = 1;
			@(posedge sys_clk);
			#1 host_rd_strobe = 0;
		end
	endtask
	// Offer bytes until the buffer refuses
	task fill(output [7:0] n);
		begin
			n = 0;
			host_wr_valid = 1;
			while (host_wr_ready && n < 40)
			begin
				host_wr_data = n;
				@(posedge sys_clk);
				#1 n++;
			end
			host_wr_valid = 0;
		end
	endtask
endmodule // host_model

/* File: tb/testbench.sv */
// Self-checking bench for the boot download handshake
`timescale 1ns/10ps
`include "boot_regs.vh"
module testbench;
	logic sys_clk = 0, sys_rst = 1, wr_strap_n = 0, rd_strap_n = 0, psel_strap = 0;
	logic setup_fault = 0, part_match = 1, begin_decode_msg = 0;
	logic host_wr_valid, host_wr_last, host_wr_ready, host_rd_strobe, out_ready_reg;
	logic host_attention_n_reg, app_reset_reg, decoding_reg, stalled_reg, serial_mode_reg;
	logic [7:0] host_wr_data, status_byte_reg, b, a, n_app = 0;
	integer n_fail = 0, checked = 0, i;
	host_boot_download_handshake DUT (.sys_clk, .sys_rst, .wr_strap_n, .rd_strap_n,
		.psel_strap, .host_wr_valid, .host_wr_data, .host_wr_last, .host_wr_ready,
		.host_rd_strobe, .status_byte_reg, .out_ready_reg, .host_attention_n_reg,
		.setup_fault, .part_match, .begin_decode_msg, .app_reset_reg, .decoding_reg,
		.stalled_reg, .serial_mode_reg);
	host_model host (.sys_clk, .host_wr_valid, .host_wr_data, .host_wr_last,
		.host_wr_ready, .host_rd_strobe, .host_attention_n_reg, .status_byte_reg);
	always #25 sys_clk = ~sys_clk;
	// Count internal application resets
	always @(posedge sys_clk)
		if (app_reset_reg === 1'b1)
			n_app <= n_app + 8'h01;
	task chk8(input logic [7:0] e, g);
		begin
			checked++;
			if (e !== g)
			begin
				n_fail++;
				$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
			end
		end
	endtask
	task chk1(input logic e, g);
		chk8({7'h00, e}, {7'h00, g});
	endtask
	task rst(input s);
		begin
			sys_rst = 1;
			wr_strap_n = !s;
			rd_strap_n = !s;
			repeat (10) @(posedge sys_clk);
			#1 sys_rst = 0;
			repeat (3) @(posedge sys_clk);
			#1 chk1(s, serial_mode_reg);
			chk1(1, host_wr_ready);
		end
	endtask
	task boot;
		begin
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			chk8(`ST_READY_FOR_IMAGE, b);
			host.send(24'h123456, 0);
			host.send(24'hABCDEF, 0);
			host.send(24'hBE0245, 1);
			host.get(b);
			chk8(`ST_IMAGE_ACCEPTED, b);
		end
	endtask
	task t_ok;
		begin
			rst(1);
			boot;
			a = n_app;
			host.send(`CMD_ACCEPT_ACK, 0);
			// Host settling wait before configuring, short since the block times nothing
			repeat (4) @(posedge sys_clk);
			#1 chk8(a + 8'h01, n_app);
			chk1(0, out_ready_reg);
			chk1(0, decoding_reg);
			begin_decode_msg = 1;
			@(posedge sys_clk);
			#1 begin_decode_msg = 0;
			chk1(1, decoding_reg);
		end
	endtask
	task t_part;
		begin
			rst(1);
			boot;
			part_match = 0;
			host.send(`CMD_ACCEPT_ACK, 0);
			host.get(b);
			chk8(`ST_PART_MISMATCH, b);
			begin_decode_msg = 1;
			@(posedge sys_clk);
			#1 begin_decode_msg = 0;
			part_match = 1;
			chk1(0, decoding_reg);
		end
	endtask
	// Bad sum stalls, then the stalled buffer fills to its depth
	task t_bad;
		begin
			rst(1);
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			host.send(24'h000010, 0);
			host.send(24'h000011, 1);
			host.get(b);
			chk8(`ST_BAD_CHECKSUM, b);
			host.fill(b);
			chk8(8'h20, b);
			chk1(1, stalled_reg);
		end
	endtask
	task t_setup;
		begin
			rst(1);
			setup_fault = 1;
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			chk8(`ST_SETUP_FAULT_A, b);
			chk1(1, stalled_reg);
			setup_fault = 0;
			rst(1);
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			chk8(`ST_READY_FOR_IMAGE, b);
		end
	endtask
	// Last flag inside a word is a load fault; a wrong code after acceptance stalls
	task t_load;
		begin
			rst(1);
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			chk8(`ST_READY_FOR_IMAGE, b);
			host.put(8'h12, 1);
			host.idle;
			host.get(b);
			chk8(`ST_LOAD_FAULT_A, b);
			chk1(1, stalled_reg);
			rst(1);
			boot;
			host.send(`CMD_START_DOWNLOAD, 0);
			host.get(b);
			chk8(`ST_UNKNOWN_COMMAND, b);
			chk1(1, stalled_reg);
		end
	endtask
	task t_cmds;
		begin
			for (i = 1; i < 4; i++)
			begin
				rst(1);
				a = n_app;
				host.send(i[23:0], 0);
				repeat (4) @(posedge sys_clk);
				#1 chk8(a + (i == 1), n_app);
				chk8(i == 1 ? 8'h00 : `ST_UNKNOWN_COMMAND, status_byte_reg);
				chk1(i != 1, stalled_reg);
			end
		end
	endtask
	task t_par;
		begin
			rst(0);
			host.send(`CMD_START_DOWNLOAD, 0);
			repeat (4) @(posedge sys_clk);
			#1 chk1(1, out_ready_reg);
			chk1(1, host_attention_n_reg);
		end
	endtask
	task test_done;
		begin
			$display("checked=%0d n_fail=%0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial
	begin
		t_ok;
		t_part;
		t_bad;
		t_setup;
		t_load;
		t_cmds;
		t_par;
		test_done;
	end
	initial
	begin
		#250000;
		n_fail++;
		test_done;
	end
endmodule // testbench
